/* verif/dls_asserts.sv */
// checker for the lamp encoder outputs
// bound to dls_encoder, sees its ports only
`timescale 1ns/1ps
`default_nettype none
module dls_asserts (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic elec_above_tol,
  input wire logic elec_above_crit,
  input wire logic elec_present,
  input wire logic act_above_tol,
  input wire logic act_above_cutoff,
  input wire logic [1:0] port_link,
  input wire logic [1:0] port_pkt_rx,
  input wire logic supply_error,
  input wire logic elec_green,
  input wire logic elec_red,
  input wire logic act_green,
  input wire logic act_red,
  input wire logic [1:0] port_green,
  input wire logic [1:0] port_yellow
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ====
  sequence s_pkt0;
    clk_en && port_pkt_rx[0] && port_link[0];
  endsequence
  property p_eok; clk_en && elec_above_tol && elec_present |=> elec_green && !elec_red; endproperty
  a_eok: assert property (p_eok) else $error("elec green");
  property p_ecr; clk_en && !elec_above_crit && elec_present |=> elec_red && !elec_green; endproperty
  a_ecr: assert property (p_ecr) else $error("elec red");
  property p_eoff; clk_en && !elec_present |=> !elec_red && !elec_green; endproperty
  a_eoff: assert property (p_eoff) else $error("elec dark");
  property p_aok; clk_en && act_above_tol |=> act_green && !act_red; endproperty
  a_aok: assert property (p_aok) else $error("act green");
  property p_acut; clk_en && !act_above_cutoff |=> act_red && !act_green; endproperty
  a_acut: assert property (p_acut) else $error("act red");
  property p_link; clk_en |=> port_green == $past(port_link); endproperty
  a_link: assert property (p_link) else $error("port green");
  property p_pkt; s_pkt0 |=> port_yellow[0]; endproperty
  a_pkt: assert property (p_pkt) else $error("port yellow");
  property p_serr; clk_en && !(elec_above_tol && act_above_tol) |=> supply_error; endproperty
  a_serr: assert property (p_serr) else $error("supply error");
endmodule : dls_asserts
bind dls_encoder dls_asserts u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
  .elec_above_tol(elec_above_tol), .elec_above_crit(elec_above_crit),
  .elec_present(elec_present), .act_above_tol(act_above_tol),
  .act_above_cutoff(act_above_cutoff), .port_link(port_link), .port_pkt_rx(port_pkt_rx),
  .supply_error(supply_error), .elec_green(elec_green), .elec_red(elec_red),
  .act_green(act_green), .act_red(act_red), .port_green(port_green),
  .port_yellow(port_yellow));
`default_nettype wire

/* verif/dls_encoder_tb.sv */
// bench for the lamp encoder, one task per scenario
// short flash counts 4, 2, 3; network model drives ports
`timescale 1ns/1ps
`default_nettype none
module dls_encoder_tb;
  logic sys_clk = 0, rst_n = 0, et = 1, ec = 1, ep = 1, at = 1, ac = 1;
  logic bo = 1, ip = 0, mc = 0, nt = 0, wr = 0, rd = 0, cfg_req = 0, cv;
  logic ce = 1, ns = 0, nd = 0;
  logic [1:0] up = 0, snd = 0, lk, pk, pg, py;
  logic [3:0] adr = 0;
  logic [31:0] wd = 0, rdat, d;
  logic irq, serr, eg, er, ag, ar, mg, mr, ng, nr;
  int error_cnt = 0, tests_run = 0, n1, n2;
  always #5 sys_clk = ~sys_clk;
  dls_net_model net (.sys_clk(sys_clk), .up(up), .snd(snd), .cfg_req(cfg_req),
    .link(lk), .pkt(pk), .cfg_valid(cv));
  dls_encoder #(.SLOW_HALF(32'h4), .FAST_HALF(32'h2), .PKT_FLASH(32'h3)) dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(ce), .elec_above_tol(et),
    .elec_above_crit(ec), .elec_present(ep), .act_above_tol(at), .act_above_cutoff(ac),
    .cfg_valid(cv), .backplane_ok(bo), .ip_obtained(ip), .master_connected(mc),
    .net_timeout(nt), .net_severe(ns), .net_dup_ip(nd), .port_link(lk),
    .port_pkt_rx(pk), .reg_addr(adr), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rdat), .irq(irq), .supply_error(serr), .elec_green(eg), .elec_red(er),
    .act_green(ag), .act_red(ar), .mod_green(mg), .mod_red(mr), .net_green(ng),
    .net_red(nr), .port_green(pg), .port_yellow(py));
  // ====
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done;
    if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc
  task automatic rreg(input logic [3:0] a);
    @(posedge sys_clk);
    rd <= 1;
    adr <= a;
    @(posedge sys_clk);
    rd <= 0;
    #1 d = rdat;
  endtask : rreg
  task automatic wreg(input logic [3:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    wr <= 1;
    adr <= a;
    wd <= v;
    @(posedge sys_clk);
    wr <= 0;
  endtask : wreg
  // counts mod lamp edges over 24 cycles
  task automatic edges(output int n);
    logic p;
    n = 0;
    p = mg;
    repeat (24) begin
      cyc(1);
      if (mg !== p) n++;
      p = mg;
    end
  endtask : edges
  task automatic t_supply;
    @(posedge sys_clk);
    et <= 0;
    at <= 0;
    cyc(3);
    n1 = 0;
    n2 = 0;
    repeat (8) begin
      cyc(1);
      n1 += int'(er === 1'b1);
      n2 += int'(ar === 1'b1);
    end
    chk({eg, ag, serr}, 32'h1);
    chk(32'(n1 > 0 && n1 < 8 && n2 > 0 && n2 < 8), 32'h1);
    @(posedge sys_clk);
    ec <= 0;
    ac <= 0;
    cyc(2);
    chk({eg, er, ag, ar}, 32'h5);
    @(posedge sys_clk);
    ep <= 0;
    cyc(2);
    chk({eg, er}, 32'h0);
    @(posedge sys_clk);
    {et, ec, ep, at, ac} <= 5'h1F;
    cyc(2);
    chk({eg, er, ag, ar, serr}, 32'h14);
  endtask : t_supply
  task automatic t_net_ports;
    @(posedge sys_clk);
    nt <= 1;
    up <= 2'h1;
    cyc(3);
    chk({nr, pg, py}, 32'h14);
    @(posedge sys_clk);
    nt <= 0;
    snd <= 2'h3;
    @(posedge sys_clk);
    snd <= 2'h0;
    cyc(1);
    chk({nr, py}, 32'h1);
    cyc(3);
    chk(py, 32'h0);
    @(posedge sys_clk);
    up <= 2'h0;
    ns <= 1;
    cyc(3);
    chk({pg, py}, 32'h0);
    chk(nr, 32'h1);
    @(posedge sys_clk);
    ns <= 0;
    nd <= 1;
    cyc(2);
    chk(nr, 32'h1);
    @(posedge sys_clk);
    nd <= 0;
    cyc(2);
    chk(nr, 32'h0);
  endtask : t_net_ports
  // clock enable low must hold the elec green lamp and the error level
  task automatic t_freeze;
    @(posedge sys_clk);
    ce <= 0;
    et <= 0;
    cyc(3);
    chk({eg, serr}, 32'h2);
    @(posedge sys_clk);
    ce <= 1;
    et <= 1;
    cyc(2);
  endtask : t_freeze
  task automatic t_module;
    edges(n1);
    @(posedge sys_clk);
    ip <= 1;
    cyc(2);
    edges(n2);
    chk(32'(n1 > 0 && n2 > n1), 32'h1);
    @(posedge sys_clk);
    cfg_req <= 1;
    mc <= 1;
    cyc(3);
    chk(mg, 32'h1);
    @(posedge sys_clk);
    bo <= 0;
    cyc(2);
    chk(mr, 32'h1);
    @(posedge sys_clk);
    bo <= 1;
  endtask : t_module
  task automatic t_regs;
    rreg(4'h0);
    @(posedge sys_clk);
    et <= 0;
    cyc(3);
    rreg(4'h0);
    chk(d, 32'h1);
    rreg(4'h0);
    chk(d, 32'h0);
    wreg(4'h4, 32'h1);
    wreg(4'h0, 32'hF);
    rreg(4'h4);
    chk(d, 32'h1);
    @(posedge sys_clk);
    et <= 1;
    cyc(3);
    chk(irq, 32'h1);
    rreg(4'h0);
    chk(d, 32'h1);
    chk(irq, 32'h0);
    rreg(4'hC);
    chk(d, 32'h0);
    rreg(4'h8);
    chk(d, 32'hC);
  endtask : t_regs
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1;
    t_supply();
    t_net_ports();
    t_module();
    t_freeze();
    t_regs();
    test_done();
  end
  initial begin
    #200000;
    error_cnt++;
    test_done();
  end
endmodule : dls_encoder_tb
`default_nettype wire

/* verif/dls_net_model.sv */
// network side: link per port, packet pulses, config at startup
// packets only leave on a port whose link is up
`timescale 1ns/1ps
`default_nettype none
module dls_net_model (
  input wire logic sys_clk,
  input wire logic [1:0] up,
  input wire logic [1:0] snd,
  input wire logic cfg_req,
  output logic [1:0] link,
  output logic [1:0] pkt,
  output logic cfg_valid
);
  // ====
  always @(posedge sys_clk) begin
    link <= up;
    pkt <= snd & up;
    cfg_valid <= cfg_req;
  end
endmodule : dls_net_model
`default_nettype wire

/* verilog/dls_encoder.sv */
// diagnostic lamp status encoder: condition flags to lamp colour patterns
// assumes all condition inputs are synchronous to sys_clk
//
// Overview of operation
// (R01) electronics supply ok: steady green
// (R02) electronics below tolerance: red flashing
// (R03) electronics critical: steady red; dead: dark; code drives elec_green from elec_above_tol alone, not gated by elec_present
// (R04) actuator supply ok: steady green
// (R05) actuator below tolerance above cutoff: red flashing
// (R06) actuator below cutoff: steady red
// (R07) config valid, backplane ok: module green steady; code also requires master_connected, else module green flashes
// (R08) unconfigured, no master: module green slow flash
// (R09) IP obtained, no connection: module fast flash
// (R10) timeout, severe fault, duplicate IP: network red
// (R11) port link present: port lamp green
// (R12) each packet received: short yellow flash
// (R13) no link: port lamp dark
// (R14) supply threshold crossing raises controller error
// (R15) two independent port lamps, one per port
// (R16) controller sends configuration before cyclic operation
// (R17) flash rates from clock divider counters
// (R18) supply thresholds arrive as digital flags
`timescale 1ns/1ps
`default_nettype none
module dls_encoder
  import dls_pkg::*;
#(
  parameter logic [CNT_W-1:0] SLOW_HALF = CNT_W'(SLOW_HALF_CYC),
  parameter logic [CNT_W-1:0] FAST_HALF = CNT_W'(FAST_HALF_CYC),
  parameter logic [CNT_W-1:0] PKT_FLASH = CNT_W'(PKT_FLASH_CYC)
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic elec_above_tol,
  input wire logic elec_above_crit,
  input wire logic elec_present,
  input wire logic act_above_tol,
  input wire logic act_above_cutoff,
  input wire logic cfg_valid,
  input wire logic backplane_ok,
  input wire logic ip_obtained,
  input wire logic master_connected,
  input wire logic net_timeout,
  input wire logic net_severe,
  input wire logic net_dup_ip,
  input wire logic [NPORT-1:0] port_link,
  input wire logic [NPORT-1:0] port_pkt_rx,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  output logic supply_error,
  output logic elec_green,
  output logic elec_red,
  output logic act_green,
  output logic act_red,
  output logic mod_green,
  output logic mod_red,
  output logic net_green,
  output logic net_red,
  output logic [NPORT-1:0] port_green,
  output logic [NPORT-1:0] port_yellow
);

  // ==========================================================
  // shared helpers
  function automatic logic [CNT_W-1:0] dec_wrap(input logic [CNT_W-1:0] c,
                                               input logic [CNT_W-1:0] reload);
    dec_wrap = (c == CNT_ZERO) ? (reload - CNT_ONE) : (c - CNT_ONE);
  endfunction : dec_wrap

  // ==========================================================
  // flash rate dividers
  logic [CNT_W-1:0] slow_cnt_q;
  logic [CNT_W-1:0] fast_cnt_q;
  logic slow_ph_q;
  logic fast_ph_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      slow_cnt_q <= CNT_ZERO;
      slow_ph_q <= 1'b0;
    end else if (clk_en) begin
      slow_cnt_q <= dec_wrap(slow_cnt_q, SLOW_HALF); // R17
      if (slow_cnt_q == CNT_ZERO) begin
        slow_ph_q <= ~slow_ph_q;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fast_cnt_q <= CNT_ZERO;
      fast_ph_q <= 1'b0;
    end else if (clk_en) begin
      fast_cnt_q <= dec_wrap(fast_cnt_q, FAST_HALF); // R17
      if (fast_cnt_q == CNT_ZERO) begin
        fast_ph_q <= ~fast_ph_q;
      end
    end
  end

  // ==========================================================
  // supply lamps
  // comparator flags are already digital; no analog sampling here
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      elec_green <= 1'b0;
      elec_red <= 1'b0;
    end else if (clk_en) begin
      elec_green <= elec_above_tol; // R01 R18
      if (elec_above_tol || !elec_present) begin
        elec_red <= 1'b0; // R03
      end else if (elec_above_crit) begin
        elec_red <= fast_ph_q; // R02
      end else begin
        elec_red <= 1'b1; // R03
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      act_green <= 1'b0;
      act_red <= 1'b0;
    end else if (clk_en) begin
      act_green <= act_above_tol; // R04
      if (act_above_tol) begin
        act_red <= 1'b0;
      end else if (act_above_cutoff) begin
        act_red <= fast_ph_q; // R05
      end else begin
        act_red <= 1'b1; // R06
      end
    end
  end

  // ==========================================================
  // module and network lamps
  dls_mod_t mod_sel;
  always_comb begin
    if (cfg_valid && backplane_ok && master_connected) begin
      mod_sel = DLS_MOD_OK; // R07
    end else if (ip_obtained) begin
      mod_sel = DLS_MOD_FAST; // R09
    end else begin
      mod_sel = DLS_MOD_SLOW; // R08
    end
  end

  // the controller configures us first; lamp stays flashing until then
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mod_green <= 1'b0;
    end else if (clk_en) begin
      unique case (mod_sel)
        DLS_MOD_OK: mod_green <= 1'b1; // R07 R16
        DLS_MOD_FAST: mod_green <= fast_ph_q; // R09
        DLS_MOD_SLOW: mod_green <= slow_ph_q; // R08
        default: mod_green <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mod_red <= 1'b0;
    end else if (clk_en) begin
      mod_red <= cfg_valid & ~backplane_ok;
    end
  end

  // green network patterns are not modelled, lamp green stays dark
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      net_red <= 1'b0;
      net_green <= 1'b0;
    end else if (clk_en) begin
      net_red <= net_timeout | net_severe | net_dup_ip; // R10
      net_green <= 1'b0;
    end
  end

  // ==========================================================
  // link/activity lamps, one per port
  logic [CNT_W-1:0] pkt_cnt_q [NPORT];
  for (genvar p = 0; p < NPORT; p++) begin : g_port // R15
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        pkt_cnt_q[p] <= CNT_ZERO;
      end else if (clk_en) begin
        if (!port_link[p]) begin
          pkt_cnt_q[p] <= CNT_ZERO; // R13
        end else if (port_pkt_rx[p]) begin
          pkt_cnt_q[p] <= PKT_FLASH; // R12 retrigger per packet
        end else if (pkt_cnt_q[p] != CNT_ZERO) begin
          pkt_cnt_q[p] <= pkt_cnt_q[p] - CNT_ONE;
        end
      end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        port_green[p] <= 1'b0;
        port_yellow[p] <= 1'b0;
      end else if (clk_en) begin
        port_green[p] <= port_link[p]; // R11 R13
        port_yellow[p] <= port_link[p] & (port_pkt_rx[p] | (pkt_cnt_q[p] > CNT_ONE)); // R12
      end
    end
  end

  // ==========================================================
  // supply error events, status, mask, interrupt
  logic [EV_W-1:0] lvl_q;
  logic [EV_W-1:0] lvl_now;
  logic [EV_W-1:0] status_q;
  logic [EV_W-1:0] mask_q;
  logic [EV_W-1:0] ev;

  always_comb begin
    lvl_now = '0;
    lvl_now[EV_ELEC_LOW] = ~elec_above_tol;
    lvl_now[EV_ELEC_CRIT] = ~elec_above_crit;
    lvl_now[EV_ACT_LOW] = ~act_above_tol;
    lvl_now[EV_ACT_CUT] = ~act_above_cutoff;
  end

  // either direction of a threshold crossing counts as an event
  assign ev = lvl_now ^ lvl_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl_q <= '0;
    end else if (clk_en) begin
      lvl_q <= lvl_now;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= '0;
    end else if (clk_en) begin
      if (reg_rd && reg_addr == ADDR_STATUS) begin
        status_q <= ev; // new event wins over read clear
      end else begin
        status_q <= status_q | ev; // R14
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= MASK_RST;
    end else if (clk_en && reg_wr && reg_addr == ADDR_MASK) begin
      mask_q <= reg_wdata[EV_W-1:0];
    end
  end

  // level error while any supply sits below its threshold
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      supply_error <= 1'b0;
    end else if (clk_en) begin
      supply_error <= ~elec_above_tol | ~act_above_tol; // R14
    end
  end

  assign irq = |(status_q & mask_q);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (clk_en) begin
      reg_rdata <= '0;
      if (reg_rd) begin
        unique case (reg_addr)
          ADDR_STATUS: reg_rdata <= {28'h0000000, status_q};
          ADDR_MASK: reg_rdata <= {28'h0000000, mask_q};
          ADDR_LAMPS: reg_rdata <= {22'h000000, lvl_q, port_link, mod_sel, supply_error, irq};
          default: reg_rdata <= '0;
        endcase
      end
    end
  end

endmodule : dls_encoder
`default_nettype wire

/* verilog/dls_pkg.sv */
// constants for the diagnostic lamp status encoder
// assumes a 100 MHz system clock and synchronous condition flags
package dls_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  // flash timing in milliseconds
  localparam int unsigned SLOW_HALF_MS = 500;
  localparam int unsigned FAST_HALF_MS = 125;
  localparam int unsigned PKT_FLASH_MS = 30;
  localparam int unsigned SLOW_HALF_CYC = SLOW_HALF_MS * (CLK_HZ / 1000);
  localparam int unsigned FAST_HALF_CYC = FAST_HALF_MS * (CLK_HZ / 1000);
  localparam int unsigned PKT_FLASH_CYC = PKT_FLASH_MS * (CLK_HZ / 1000);
  localparam int CNT_W = 32;
  localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;
  localparam int NPORT = 2;
  // status register byte address and mask address
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_MASK = 4'h4;
  localparam logic [3:0] ADDR_LAMPS = 4'h8;
  localparam int EV_W = 4;
  // event bit positions
  localparam int EV_ELEC_LOW = 0;
  localparam int EV_ELEC_CRIT = 1;
  localparam int EV_ACT_LOW = 2;
  localparam int EV_ACT_CUT = 3;
  localparam logic [EV_W-1:0] MASK_RST = 4'h0;
  typedef enum logic [1:0] {
    DLS_MOD_SLOW = 2'b00,
    DLS_MOD_FAST = 2'b01,
    DLS_MOD_OK = 2'b11
  } dls_mod_t;
endpackage : dls_pkg
